// file: clk_timer_pkg.sv
/*
 * shared constants and types of the tick clock timer: register indices,
 * field positions, timing counts and the structs that carry counter state.
 * assumes a single 100 MHz system clock and an AXI4-Lite register bus.
 */
package clk_timer_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ    = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_HZ       = 256;
    localparam int unsigned TICK_CYCLES   = SYS_CLK_HZ / TICK_HZ;
    localparam int unsigned HOLD_MIN_NS   = 480_000;
    localparam int unsigned HOLD_MAX_NS   = 1_500_000;
    // longest time, rounded down
    localparam int unsigned HOLD_CYCLES   = HOLD_MAX_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // register map (word index, byte address is four times it)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W      = 18;
    localparam int unsigned IDX_W       = 16;
    localparam logic [15:0] IDX_CONTROL = 16'hFF78;
    localparam logic [15:0] IDX_CNT_LO  = 16'hFF79;
    localparam logic [15:0] IDX_CNT_HI  = 16'hFF7A;
    localparam logic [15:0] IDX_MASK    = 16'hFFE6;
    localparam logic [15:0] IDX_FLAGS   = 16'hFFF6;

    localparam int unsigned CTRL_RUN_BIT   = 0;
    localparam int unsigned CTRL_CLEAR_BIT = 1;
    localparam logic [3:0]  MASK_RESET     = 4'h0;
    localparam logic [3:0]  FLAGS_RESET    = 4'h0;

    // counter bit feeding each flag: 32 Hz, 8 Hz, 2 Hz, 1 Hz
    localparam int unsigned NUM_TAPS = 4;
    localparam int unsigned TAP_BIT [NUM_TAPS] = '{2, 4, 6, 7};

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef logic [3:0] nibble_t;

    typedef struct packed {
        nibble_t hi;
        nibble_t lo;
    } count_t;

    typedef struct packed {
        logic             en;
        logic [IDX_W-1:0] idx;
        nibble_t          data;
    } reg_wr_t;

    typedef enum logic [1:0] {
        HOLD_FREE   = 2'b01,
        HOLD_FROZEN = 2'b10
    } hold_state_t;

endpackage

// file: clock_timer_top.sv
/*
 * free-running 8-bit tick counter with high-nibble hold, run/clear
 * control and four maskable tick interrupts behind an AXI4-Lite slave.
 * assumes one clock, a synchronous active-low reset and a master that
 * keeps at most one write and one read under way.
 */
// The AXI4-Lite register port was decided locally.
module clock_timer_top
    import clk_timer_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES,
    parameter int unsigned HOLD_LEN = HOLD_CYCLES
)
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   irq
);

    localparam int unsigned HC_W = $clog2(HOLD_LEN);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic              aw_held_q, aw_held_d;
    logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
    logic              w_held_q, w_held_d;
    nibble_t           w_data_q, w_data_d;
    logic              w_strb_q, w_strb_d;
    logic              awready_q, awready_d;
    logic              wready_q, wready_d;
    logic              bvalid_q, bvalid_d;
    logic [1:0]        bresp_q, bresp_d;
    logic              arready_q, arready_d;
    logic              rvalid_q, rvalid_d;
    logic [31:0]       rdata_q, rdata_d;
    logic [1:0]        rresp_q, rresp_d;
    logic              run_q, run_d;
    nibble_t           mask_q, mask_d;
    logic              irq_q, irq_d;

    count_t            count_q, count_d;
    logic              pend_q, pend_d;
    hold_state_t       hold_q, hold_d;
    logic [HC_W-1:0]   hcnt_q, hcnt_d;

    logic              do_write;
    logic              wr_ok;
    reg_wr_t           wr_w;
    logic              rd_hs;
    logic [IDX_W-1:0]  rd_idx;
    logic              rd_ok;
    logic              low_read;
    logic              high_read;
    logic              clr_w;
    logic              release_w;
    logic              tick;
    nibble_t           flags;
    nibble_t           flag_clr;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
        idx_mapped = (idx == IDX_CONTROL) || (idx == IDX_CNT_LO) ||
                     (idx == IDX_CNT_HI) || (idx == IDX_MASK) ||
                     (idx == IDX_FLAGS);
    endfunction

    assign do_write = aw_held_q & w_held_q & ~bvalid_q;
    assign wr_ok    = (aw_addr_q[1:0] == 2'h0) &&
                      idx_mapped(aw_addr_q[ADDR_W-1:2]);
    // only the low byte lane carries data
    assign wr_w.en   = do_write & wr_ok & w_strb_q;
    assign wr_w.idx  = aw_addr_q[ADDR_W-1:2];
    assign wr_w.data = w_data_q;

    assign rd_hs     = s_axi_arvalid & arready_q;
    assign rd_idx    = s_axi_araddr[ADDR_W-1:2];
    assign rd_ok     = (s_axi_araddr[1:0] == 2'h0) && idx_mapped(rd_idx);
    assign low_read  = rd_hs && rd_ok && (rd_idx == IDX_CNT_LO);
    assign high_read = rd_hs && rd_ok && (rd_idx == IDX_CNT_HI);

    assign clr_w = wr_w.en && (wr_w.idx == IDX_CONTROL) &&
                   wr_w.data[CTRL_CLEAR_BIT];

    // hold ends on high read or timeout
    assign release_w = (hold_q == HOLD_FROZEN) &&
                       (high_read || (hcnt_q == '0));

    // ------------------------------------------------------------
    // bus slave and registers
    // ------------------------------------------------------------
    always_comb
    begin
        aw_held_d = aw_held_q;
        aw_addr_d = aw_addr_q;
        w_held_d  = w_held_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        run_d     = run_q;
        mask_d    = mask_q;
        if (s_axi_awvalid && awready_q)
        begin
            aw_held_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q)
        begin
            w_held_d = 1'b1;
            w_data_d = s_axi_wdata[3:0];
            w_strb_d = s_axi_wstrb[0];
        end
        if (bvalid_q && s_axi_bready)
            bvalid_d = 1'b0;
        if (do_write)
        begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        if (wr_w.en && (wr_w.idx == IDX_CONTROL))
            run_d = wr_w.data[CTRL_RUN_BIT];
        if (wr_w.en && (wr_w.idx == IDX_MASK))
            mask_d = wr_w.data;
        if (rvalid_q && s_axi_rready)
            rvalid_d = 1'b0;
        if (rd_hs)
        begin
            rvalid_d = 1'b1;
            rresp_d  = rd_ok ? RESP_OKAY : RESP_SLVERR;
            rdata_d  = 32'h0;
            if (rd_ok)
            begin
                case (rd_idx)
                    IDX_CONTROL: rdata_d[CTRL_RUN_BIT] = run_q;
                    IDX_CNT_LO:  rdata_d[3:0] = count_q.lo;
                    IDX_CNT_HI:  rdata_d[3:0] = count_q.hi;
                    IDX_MASK:    rdata_d[3:0] = mask_q;
                    IDX_FLAGS:   rdata_d[3:0] = flags;
                    default:     rdata_d = 32'h0;
                endcase
            end
        end
        awready_d = ~aw_held_d & ~bvalid_d;
        wready_d  = ~w_held_d & ~bvalid_d;
        arready_d = ~rvalid_d;
        irq_d = |(flags & mask_q);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            w_held_q  <= 1'b0;
            w_data_q  <= 4'h0;
            w_strb_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0;
            rresp_q   <= RESP_OKAY;
            run_q     <= 1'b0;
            mask_q    <= MASK_RESET;
            irq_q     <= 1'b0;
        end
        else
        begin
            aw_held_q <= aw_held_d;
            aw_addr_q <= aw_addr_d;
            w_held_q  <= w_held_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            arready_q <= arready_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
            run_q     <= run_d;
            mask_q    <= mask_d;
            irq_q     <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // counter and hold
    // ------------------------------------------------------------
    tick_prescaler #(
        .DIV (TICK_DIV)
    ) u_prescaler (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick)
    );

    always_comb
    begin
        count_d = count_q;
        pend_d  = pend_q;
        hold_d  = hold_q;
        hcnt_d  = hcnt_q;
        case (hold_q)
            HOLD_FREE:
                if (low_read)
                begin
                    hold_d = HOLD_FROZEN;
                    hcnt_d = HC_W'(HOLD_LEN - 1);
                end
            HOLD_FROZEN:
                if (release_w)
                    hold_d = HOLD_FREE;
                else
                    hcnt_d = hcnt_q - HC_W'(1);
            default:
                hold_d = HOLD_FREE;
        endcase
        // deferred carry lands once the hold lets go
        if (release_w && pend_q)
        begin
            count_d.hi = count_q.hi + 4'h1;
            pend_d     = 1'b0;
        end
        if (tick && run_q)
        begin
            count_d.lo = count_q.lo + 4'h1;
            if (count_q.lo == 4'hF)
            begin
                if (hold_d == HOLD_FROZEN)
                    pend_d = 1'b1;
                else
                    count_d.hi = count_d.hi + 4'h1;
            end
        end
        if (clr_w)
        begin
            count_d = '0;
            pend_d  = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            count_q <= '0;
            pend_q  <= 1'b0;
            hold_q  <= HOLD_FREE;
            hcnt_q  <= '0;
        end
        else
        begin
            count_q <= count_d;
            pend_q  <= pend_d;
            hold_q  <= hold_d;
            hcnt_q  <= hcnt_d;
        end
    end

    // ------------------------------------------------------------
    // tick flags
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_TAPS; i++)
    begin : g_flag
        assign flag_clr[i] = wr_w.en && (wr_w.idx == IDX_FLAGS) && wr_w.data[i];
        // set on tap fall, mask ignored
        tick_flag u_flag (
            .aclk    (aclk),
            .aresetn (aresetn),
            .tap     (count_q[TAP_BIT[i]]),
            .clear   (flag_clr[i]),
            .flag    (flags[i])
        );
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign irq           = irq_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_step;
        @(posedge aclk) disable iff (!aresetn)
        (tick && run_q && !clr_w) |=> (count_q.lo == 4'($past(count_q.lo) + 4'h1));
    endproperty
    a_step: assert property (p_step) else $error("count did not step on tick");

    property p_idle;
        @(posedge aclk) disable iff (!aresetn)
        ((!tick || !run_q) && !clr_w) |=> $stable(count_q.lo);
    endproperty
    a_idle: assert property (p_idle) else $error("count moved without tick");

    property p_clear;
        @(posedge aclk) disable iff (!aresetn)
        clr_w |=> (count_q == '0) && !pend_q;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not zero count");

    property p_ctrl_rd;
        @(posedge aclk) disable iff (!aresetn)
        (rd_hs && rd_ok && rd_idx == IDX_CONTROL) |=>
            (rdata_q[3:1] == 3'h0) && (rdata_q[CTRL_RUN_BIT] == $past(run_q));
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read wrong");

    property p_lo_rd;
        @(posedge aclk) disable iff (!aresetn)
        low_read |=> rvalid_q && (rdata_q[3:0] == $past(count_q.lo)) &&
                     (hold_q == HOLD_FROZEN);
    endproperty
    a_lo_rd: assert property (p_lo_rd) else $error("low read wrong or no hold");

    property p_freeze;
        @(posedge aclk) disable iff (!aresetn)
        (hold_q == HOLD_FROZEN && !release_w && !clr_w) |=> $stable(count_q.hi);
    endproperty
    a_freeze: assert property (p_freeze) else $error("high moved while held");

    property p_timeout;
        @(posedge aclk) disable iff (!aresetn)
        (hold_q == HOLD_FROZEN && hcnt_q == '0) |=> (hold_q == HOLD_FREE);
    endproperty
    a_timeout: assert property (p_timeout) else $error("hold outlived timeout");

    property p_fall32;
        @(posedge aclk) disable iff (!aresetn)
        $fell(count_q[TAP_BIT[0]]) |=> flags[0];
    endproperty
    a_fall32: assert property (p_fall32) else $error("32 Hz flag not set");

    property p_w1c;
        @(posedge aclk) disable iff (!aresetn)
        (flag_clr[3] && !$fell(count_q[TAP_BIT[3]])) |=> !flags[3];
    endproperty
    a_w1c: assert property (p_w1c) else $error("1 Hz flag not cleared");

    property p_mask;
        @(posedge aclk) disable iff (!aresetn)
        (wr_w.en && wr_w.idx == IDX_MASK) |=> (mask_q == $past(wr_w.data));
    endproperty
    a_mask: assert property (p_mask) else $error("mask not written");

    property p_irq;
        @(posedge aclk) disable iff (!aresetn)
        (|(flags & mask_q)) |=> irq_q;
    endproperty
    a_irq: assert property (p_irq) else $error("request missing");

    property p_no_irq;
        @(posedge aclk) disable iff (!aresetn)
        (mask_q == 4'h0 && $stable(mask_q)) |=> !irq_q;
    endproperty
    a_no_irq: assert property (p_no_irq) else $error("request while all masked");

endmodule

// file: clock_timer_top_test.sv
/*
 * self-checking bench of the tick clock timer: an AXI4-Lite master with
 * queued expectations, a response watcher and irq spot checks.
 * assumes TICK_DIV 16 and HOLD_LEN 100, well inside a low-nibble wrap.
 */
module clock_timer_top_test
    import clk_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int TDIV = 16;
    localparam int HLEN = 100;
    logic              aclk;
    logic              aresetn;
    logic [ADDR_W-1:0] s_axi_awaddr;
    logic              s_axi_awvalid;
    logic              s_axi_awready;
    logic [31:0]       s_axi_wdata;
    logic [3:0]        s_axi_wstrb;
    logic              s_axi_wvalid;
    logic              s_axi_wready;
    logic [1:0]        s_axi_bresp;
    logic              s_axi_bvalid;
    logic              s_axi_bready;
    logic [ADDR_W-1:0] s_axi_araddr;
    logic              s_axi_arvalid;
    logic              s_axi_arready;
    logic [31:0]       s_axi_rdata;
    logic [1:0]        s_axi_rresp;
    logic              s_axi_rvalid;
    logic              s_axi_rready;
    logic              irq;
    logic [33:0]       rq[$];
    logic [1:0]        bq[$];
    int                miscompares;
    int                check_count;
    int                cyc;
    int                seed;
    int                i;
    logic [3:0]        m;

    clock_timer_top #(.TICK_DIV(TDIV), .HOLD_LEN(HLEN)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq)
    );

    always #5 aclk = ~aclk;
    always @(posedge aclk) cyc <= cyc + 1;

    // ------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [33:0] e, input logic [33:0] g);
        check_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic chk_irq(input logic e);
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk("irq", {33'h0, e}, {33'h0, irq});
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // response watcher: oldest note against each answer
    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready)
            chk("read", (rq.size() > 0) ? rq.pop_front() : {2'h3, 32'h0},
                {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready)
            chk("bresp", {32'h0, (bq.size() > 0) ? bq.pop_front() : 2'h3},
                {32'h0, s_axi_bresp});
    end

    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] r);
        int n;
        bq.push_back(r);
        repeat (2) @(posedge aclk);
        s_axi_awaddr  <= {idx, 2'b00};
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hF;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
                break;
        end
        s_axi_bready <= 1'b0;
        if (n == 100)
        begin
            miscompares++;
            tally_and_finish();
        end
    endtask

    task automatic rd(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] r);
        int n;
        rq.push_back({r, d});
        repeat (2) @(posedge aclk);
        s_axi_araddr  <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
                break;
        end
        s_axi_rready <= 1'b0;
        if (n == 100)
        begin
            miscompares++;
            tally_and_finish();
        end
    endtask

    // run for exactly k ticks: both writes land 16k edges apart
    task automatic run_for(input int k, input logic [31:0] start);
        int t0;
        @(posedge aclk);
        t0 = cyc;
        wr(IDX_CONTROL, start, RESP_OKAY);
        while (cyc < t0 + TDIV * k)
            @(posedge aclk);
        wr(IDX_CONTROL, 32'h0, RESP_OKAY);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        aclk = 1'b0;
        aresetn = 1'b0;
        cyc = 0;
        seed = 141;
        miscompares = 0;
        check_count = 0;
        s_axi_awaddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = '0;
        s_axi_wstrb = '0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(IDX_CONTROL, 32'h0, RESP_OKAY);
        rd(IDX_CNT_LO, 32'h0, RESP_OKAY);
        rd(IDX_CNT_HI, 32'h0, RESP_OKAY);
        rd(IDX_MASK, 32'h0, RESP_OKAY);
        rd(IDX_FLAGS, 32'h0, RESP_OKAY);
        run_for(20, 32'h1);
        rd(IDX_CNT_LO, 32'h4, RESP_OKAY);
        rd(IDX_CNT_HI, 32'h1, RESP_OKAY);
        repeat (40) @(posedge aclk);
        rd(IDX_CNT_LO, 32'h4, RESP_OKAY); // stopped keeps count
        run_for(3, 32'h1);
        rd(IDX_CNT_LO, 32'h7, RESP_OKAY); // resumes from kept count
        wr(IDX_CNT_LO, 32'hF, RESP_OKAY);
        rd(IDX_CNT_LO, 32'h7, RESP_OKAY);
        rd(IDX_FLAGS, 32'h1, RESP_OKAY);
        chk_irq(1'b0); // masked
        // clear drops both taps, so both flags set
        wr(IDX_CONTROL, 32'h2, RESP_OKAY);
        rd(IDX_CONTROL, 32'h0, RESP_OKAY); // strobe reads zero
        repeat (40) @(posedge aclk);
        rd(IDX_CNT_LO, 32'h0, RESP_OKAY);
        rd(IDX_CNT_HI, 32'h0, RESP_OKAY);
        rd(IDX_FLAGS, 32'h3, RESP_OKAY);
        wr(IDX_MASK, 32'h1, RESP_OKAY);
        chk_irq(1'b1);
        wr(IDX_FLAGS, 32'h2, RESP_OKAY);
        rd(IDX_FLAGS, 32'h1, RESP_OKAY); // zero bits untouched
        chk_irq(1'b1);
        wr(IDX_FLAGS, 32'h1, RESP_OKAY); // serviced flag cleared
        rd(IDX_FLAGS, 32'h0, RESP_OKAY);
        chk_irq(1'b0);
        for (i = 0; i < 4; i++)
        begin
            m = 4'($random(seed));
            wr(IDX_MASK, {28'h0, m}, RESP_OKAY);
            rd(IDX_MASK, {28'h0, m}, RESP_OKAY);
            chk_irq(1'b0); // no flag pending
        end
        wr(IDX_MASK, 32'h0, RESP_OKAY);
        // hold released by the high read
        run_for(15, 32'h1);
        rd(IDX_CNT_LO, 32'hF, RESP_OKAY);
        run_for(1, 32'h1);
        rd(IDX_CNT_HI, 32'h0, RESP_OKAY); // carry held
        rd(IDX_CNT_HI, 32'h1, RESP_OKAY); // carry added
        rd(IDX_CNT_LO, 32'h0, RESP_OKAY);
        // hold released by the timeout
        run_for(15, 32'h1);
        rd(IDX_CNT_LO, 32'hF, RESP_OKAY);
        run_for(1, 32'h1);
        repeat (HLEN + 10) @(posedge aclk);
        rd(IDX_CNT_HI, 32'h2, RESP_OKAY); // timeout ends hold
        run_for(2, 32'h3); // clear in the same write that starts the run
        rd(IDX_CNT_LO, 32'h2, RESP_OKAY);
        rd(IDX_CNT_HI, 32'h0, RESP_OKAY);
        wr(IDX_CONTROL, 32'h1, RESP_OKAY);
        rd(IDX_CONTROL, 32'h1, RESP_OKAY); // run bit reads back
        wr(IDX_CONTROL, 32'h0, RESP_OKAY);
        wr(16'h0000, 32'hF, RESP_SLVERR); // unmapped
        rd(16'h0000, 32'h0, RESP_SLVERR); // unmapped
        repeat (4) @(posedge aclk);
        tally_and_finish();
    end
endmodule

// file: tick_flag.sv
/*
 * one sticky interrupt flag set on the falling edge of a counter tap.
 * clear is a one-cycle write-one pulse; a fall in the same cycle wins.
 */
module tick_flag
    import clk_timer_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic tap,
    input  wire logic clear,
    output logic      flag
);

    logic prev_q;
    logic flag_q;
    logic flag_d;

    // set beats clear so no event is lost
    always_comb
    begin
        flag_d = (prev_q & ~tap) | (flag_q & ~clear);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prev_q <= 1'b0;
            flag_q <= 1'b0;
        end
        else
        begin
            prev_q <= tap;
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;

endmodule

// file: tick_prescaler.sv
/*
 * divides the system clock down to a one-cycle tick every DIV cycles.
 * assumes DIV is at least 2; runs from reset onward, never stops.
 */
module tick_prescaler
    import clk_timer_pkg::*;
#(
    parameter int unsigned DIV = TICK_CYCLES
)
(
    input  wire logic aclk,
    input  wire logic aresetn,
    output logic      tick
);

    localparam int unsigned CW = $clog2(DIV);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          tick_q;
    logic          tick_d;

    always_comb
    begin
        tick_d = (cnt_q == CW'(DIV - 1));
        cnt_d  = tick_d ? '0 : cnt_q + CW'(1);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule
